// file: src/aac_consts.vh
`ifndef AAC_CONSTS_VH
`define AAC_CONSTS_VH

// widths
`define AAC_DATA_W 8
`define AAC_INSN_W 14
`define AAC_PC_W 12
`define AAC_FADDR_W 8

// instruction cycle is four oscillator periods
`define AAC_OSC_PERIOD_NS 100
`define AAC_PHASES_PER_CYCLE 4

// instruction classes, bits 13:12
`define AAC_CLS_FILE 2'h0
`define AAC_CLS_LIT 2'h1
`define AAC_CLS_GOTO 2'h2
`define AAC_CLS_ACC 2'h3

// alu operations, bits 11:8
`define AAC_OP_MOVA 4'h0
`define AAC_OP_CLR 4'h1
`define AAC_OP_SUB 4'h2
`define AAC_OP_DEC 4'h3
`define AAC_OP_IOR 4'h4
`define AAC_OP_AND 4'h5
`define AAC_OP_XOR 4'h6
`define AAC_OP_ADD 4'h7
`define AAC_OP_MOVB 4'h8
`define AAC_OP_COM 4'h9
`define AAC_OP_INC 4'ha
`define AAC_OP_RRF 4'hb
`define AAC_OP_RLF 4'hc
`define AAC_OP_SWAP 4'hd

// core-held special registers, low seven address bits
`define AAC_SFR_INDF 7'h00
`define AAC_SFR_PCL 7'h02
`define AAC_SFR_STATUS 7'h03
`define AAC_SFR_FSR 7'h04
`define AAC_SFR_PCH 7'h0a

// status register bit positions
`define AAC_ST_C 0
`define AAC_ST_DC 1
`define AAC_ST_Z 2
`define AAC_ST_RP 5

// reset values
`define AAC_RST_STATUS 8'h00
`define AAC_RST_ACC 8'h00
`define AAC_RST_FSR 8'h00
`define AAC_RST_PC 12'h000

`endif

// file: src/aac_alu.v
`timescale 1ns/10ps
`default_nettype none
`include "aac_consts.vh"

module aac_alu (
  input wire [7:0] a,
  input wire [7:0] b,
  input wire [3:0] op,
  input wire carry_in,
  output reg [7:0] result,
  output reg carry_out,
  output reg dc_out,
  output reg upd_c,
  output reg upd_dc,
  output reg upd_z
);

  // returns {digit carry, carry, sum}; subtraction feeds ~a and cin=1
  function [9:0] add_w;
    input [7:0] x;
    input [7:0] y;
    input cin;
    reg [8:0] s;
    reg [4:0] n;
    begin
      s = {1'b0, x} + {1'b0, y} + {8'h00, cin};
      n = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
      add_w = {n[4], s};
    end
  endfunction

  reg [9:0] sum;

  always @* begin
    sum = 10'h000;
    result = b;
    carry_out = carry_in;
    dc_out = 1'b0;
    upd_c = 1'b0;
    upd_dc = 1'b0;
    upd_z = 1'b1;
    case (op)
      `AAC_OP_MOVA: begin
        result = a;
        upd_z = 1'b0;
      end
      `AAC_OP_CLR: result = 8'h00;
      `AAC_OP_SUB: begin
        // carry set means no borrow, in both byte and nibble
        sum = add_w(b, ~a, 1'b1);
        result = sum[7:0];
        carry_out = sum[8];
        dc_out = sum[9];
        upd_c = 1'b1;
        upd_dc = 1'b1;
      end
      `AAC_OP_DEC: result = b - 8'h01;
      `AAC_OP_IOR: result = a | b;
      `AAC_OP_AND: result = a & b;
      `AAC_OP_XOR: result = a ^ b;
      `AAC_OP_ADD: begin
        sum = add_w(a, b, 1'b0);
        result = sum[7:0];
        carry_out = sum[8];
        dc_out = sum[9];
        upd_c = 1'b1;
        upd_dc = 1'b1;
      end
      `AAC_OP_MOVB: result = b;
      `AAC_OP_COM: result = ~b;
      `AAC_OP_INC: result = b + 8'h01;
      `AAC_OP_RRF: begin
        result = {carry_in, b[7:1]};
        carry_out = b[0];
        upd_c = 1'b1;
        upd_z = 1'b0;
      end
      `AAC_OP_RLF: begin
        result = {b[6:0], carry_in};
        carry_out = b[7];
        upd_c = 1'b1;
        upd_z = 1'b0;
      end
      `AAC_OP_SWAP: begin
        result = {b[3:0], b[7:4]};
        upd_z = 1'b0;
      end
      default: upd_z = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

// file: src/aac_core.v
// Function
// - the arithmetic unit is eight bits wide and adds, subtracts, shifts and does logic.
// - arithmetic treats operands and results as two's complement bytes.
// - two-operand work takes the accumulator plus a file register or a literal.
// - single-operand work acts on the accumulator or on one file register.
// - the accumulator is an eight-bit register that no data address reaches.
// - instructions update carry, digit carry and zero in the status register.
// - in subtraction carry and digit carry mean no borrow and no nibble borrow.
// - program and data use separate buses so instruction width is free of data width.
// - every instruction is one 14-bit word fetched whole in one cycle.
// - fetch of the next word overlaps execution, one cycle per non-branch.
// - the core addresses 4K program words and 176 bytes of general data.
// - file registers are reached directly or indirectly through a pointer.
// - status, pointer and program counter sit in the data address space.
// - any alu operation works on any register in any addressing mode.
// - the instruction cycle is a quarter of the oscillator, shown on a pin in rc mode.
// - a low master clear holds the core in reset.
`timescale 1ns/10ps
`default_nettype none
`include "aac_consts.vh"

module aac_core #(
  parameter PC_W = `AAC_PC_W,
  parameter GEN_RAM_BYTES = 176
) (
  input wire ref_clk,
  input wire reset,
  input wire master_clear_n,
  input wire rc_mode,
  output reg [PC_W-1:0] prog_addr,
  input wire [13:0] prog_data,
  output reg [7:0] file_addr,
  input wire [7:0] file_rd_data,
  output reg file_wr_en,
  output reg [7:0] file_wr_data,
  output reg cycle_clock_out,
  output reg [7:0] acc_value,
  output reg [7:0] status_value
);

  localparam [3:0] PH_Q1 = 4'b0001;
  localparam [3:0] PH_Q2 = 4'b0010;
  localparam [3:0] PH_Q3 = 4'b0100;
  localparam [3:0] PH_Q4 = 4'b1000;

  // master clear synchroniser: a change counts when stages two and three agree
  reg master_clear_n_s1;
  reg master_clear_n_s2;
  reg master_clear_n_s3;
  reg master_clear_n_level;

  always @(posedge ref_clk) begin
    if (reset) begin
      master_clear_n_s1 <= 1'b0;
      master_clear_n_s2 <= 1'b0;
      master_clear_n_s3 <= 1'b0;
      master_clear_n_level <= 1'b0;
    end else begin
      master_clear_n_s1 <= master_clear_n;
      master_clear_n_s2 <= master_clear_n_s1;
      master_clear_n_s3 <= master_clear_n_s2;
      if (master_clear_n_s2 == master_clear_n_s3) begin
        master_clear_n_level <= master_clear_n_s3;
      end
    end
  end

  wire core_rst = reset | ~master_clear_n_level;

  reg [3:0] phase;
  reg [13:0] ir;
  reg ir_valid;
  reg [PC_W-1:0] pc;
  reg [7:0] acc;
  reg [7:0] status;
  reg [7:0] fsr;
  reg [7:0] pch;
  reg [7:0] operand;
  reg branch_pending;
  reg [PC_W-1:0] branch_target;

  // decode of the instruction in execution
  wire [1:0] cls = ir[13:12];
  wire [3:0] op = ir[11:8];
  wire [6:0] fld = ir[6:0];
  wire is_file = (cls == `AAC_CLS_FILE);
  wire to_file = is_file & ir[7];

  // direct uses the bank bit, the pointer cell selects indirect
  wire [7:0] eff_addr = (fld == `AAC_SFR_INDF) ? fsr :
                        {status[`AAC_ST_RP], fld};

  function is_internal;
    input [7:0] addr;
    begin
      is_internal = (addr[6:0] == `AAC_SFR_INDF) |
                    (addr[6:0] == `AAC_SFR_PCL) |
                    (addr[6:0] == `AAC_SFR_STATUS) |
                    (addr[6:0] == `AAC_SFR_FSR) |
                    (addr[6:0] == `AAC_SFR_PCH);
    end
  endfunction

  // indirect through the pointer cell itself reads as zero
  reg [7:0] int_rd;
  always @* begin
    int_rd = 8'h00;
    if (file_addr[6:0] == `AAC_SFR_PCL) begin
      int_rd = pc[7:0];
    end else if (file_addr[6:0] == `AAC_SFR_STATUS) begin
      int_rd = status;
    end else if (file_addr[6:0] == `AAC_SFR_FSR) begin
      int_rd = fsr;
    end else if (file_addr[6:0] == `AAC_SFR_PCH) begin
      int_rd = pch;
    end
  end

  wire [7:0] alu_res;
  wire alu_c;
  wire alu_dc;
  wire upd_c;
  wire upd_dc;
  wire upd_z;

  // file class feeds a file byte, literal class a constant, acc class w
  aac_alu u_alu (
    .a(acc),
    .b(operand),
    .op(op),
    .carry_in(status[`AAC_ST_C]),
    .result(alu_res),
    .carry_out(alu_c),
    .dc_out(alu_dc),
    .upd_c(upd_c),
    .upd_dc(upd_dc),
    .upd_z(upd_z)
  );

  // an explicit status write lands first, then the flags of the operation
  reg [7:0] next_status;
  always @* begin
    next_status = status;
    if (to_file && file_addr[6:0] == `AAC_SFR_STATUS) begin
      next_status = alu_res;
    end
    if (upd_c) begin
      next_status[`AAC_ST_C] = alu_c;
    end
    if (upd_dc) begin
      next_status[`AAC_ST_DC] = alu_dc;
    end
    if (upd_z) begin
      next_status[`AAC_ST_Z] = (alu_res == 8'h00);
    end
  end

  wire [PC_W-1:0] pc_inc = pc + {{(PC_W-1){1'b0}}, 1'b1};
  wire [PC_W-1:0] pcl_target = {pch[PC_W-9:0], alu_res};

  // low seven bits select a core register in either bank
  function sfr_hit;
    input [7:0] addr;
    input [6:0] code;
    begin
      sfr_hit = (addr[6:0] == code);
    end
  endfunction

  // phase decodes; each phase owns one slice of the instruction cycle
  wire in_q1 = (phase == PH_Q1);
  wire in_q2 = (phase == PH_Q2);
  wire in_q3 = (phase == PH_Q3);
  wire in_q4 = (phase == PH_Q4);
  wire is_goto = (cls == `AAC_CLS_GOTO);

  // phase sequencer and the quarter-rate cycle clock
  always @(posedge ref_clk) begin
    if (core_rst) begin
      phase <= PH_Q1;
      cycle_clock_out <= 1'b0;
    end else begin
      case (phase)
        PH_Q1: begin
          phase <= PH_Q2;
          cycle_clock_out <= 1'b0;
        end
        PH_Q2: begin
          phase <= PH_Q3;
        end
        PH_Q3: begin
          phase <= PH_Q4;
          cycle_clock_out <= rc_mode;
        end
        PH_Q4: begin
          phase <= PH_Q1;
        end
        default: begin
          // a lost phase code falls back to q1 rather than hanging
          phase <= PH_Q1;
          cycle_clock_out <= 1'b0;
        end
      endcase
    end
  end

  // address goes out at q1 so the far side has a full phase to answer
  always @(posedge ref_clk) begin
    if (core_rst) begin
      file_addr <= 8'h00;
      operand <= 8'h00;
    end else if (in_q1) begin
      file_addr <= eff_addr;
    end else if (in_q2) begin
      if (cls == `AAC_CLS_LIT) begin
        operand <= ir[7:0];
      end else if (cls == `AAC_CLS_ACC) begin
        operand <= acc;
      end else if (is_internal(file_addr)) begin
        operand <= int_rd;
      end else begin
        operand <= file_rd_data;
      end
    end
  end

  // fetch side: a branch is resolved in q3 and takes effect at q4
  always @(posedge ref_clk) begin
    if (core_rst) begin
      ir <= 14'h0000;
      ir_valid <= 1'b0;
      pc <= `AAC_RST_PC;
      prog_addr <= `AAC_RST_PC;
      branch_pending <= 1'b0;
      branch_target <= `AAC_RST_PC;
    end else if (in_q3 && ir_valid) begin
      if (is_goto) begin
        branch_pending <= 1'b1;
        branch_target <= ir[PC_W-1:0];
      end else if (to_file && sfr_hit(file_addr, `AAC_SFR_PCL)) begin
        branch_pending <= 1'b1;
        branch_target <= pcl_target;
      end
    end else if (in_q4) begin
      ir <= prog_data;
      // the word now taken was prefetched, so a branch throws it away
      ir_valid <= ~branch_pending;
      branch_pending <= 1'b0;
      if (branch_pending) begin
        pc <= branch_target;
        prog_addr <= branch_target;
      end else begin
        pc <= pc_inc;
        prog_addr <= pc_inc;
      end
    end
  end

  // execute at q3; the write strobe stands for the q4 phase only
  always @(posedge ref_clk) begin
    if (core_rst) begin
      acc <= `AAC_RST_ACC;
      status <= `AAC_RST_STATUS;
      fsr <= `AAC_RST_FSR;
      pch <= 8'h00;
      file_wr_en <= 1'b0;
      file_wr_data <= 8'h00;
    end else if (in_q3 && ir_valid && !is_goto) begin
      status <= next_status;
      if (!to_file) begin
        acc <= alu_res;
      end else if (!is_internal(file_addr)) begin
        file_wr_en <= 1'b1;
        file_wr_data <= alu_res;
      end else if (sfr_hit(file_addr, `AAC_SFR_FSR)) begin
        fsr <= alu_res;
      end else if (sfr_hit(file_addr, `AAC_SFR_PCH)) begin
        pch <= alu_res;
      end
    end else if (in_q4) begin
      file_wr_en <= 1'b0;
    end
  end

  // mirrors lag the core by one clock; outputs stay flip-flop driven
  always @(posedge ref_clk) begin
    if (core_rst) begin
      acc_value <= `AAC_RST_ACC;
      status_value <= `AAC_RST_STATUS;
    end else begin
      acc_value <= acc;
      status_value <= status;
    end
  end

endmodule
`default_nettype wire

// file: testbench/aac_core_props.sv
`timescale 1ns/10ps
`default_nettype none
module aac_core_props #(
  parameter PC_W = 12
) (
  input wire ref_clk,
  input wire reset,
  input wire master_clear_n,
  input wire rc_mode,
  input wire [PC_W-1:0] prog_addr,
  input wire [7:0] file_addr,
  input wire file_wr_en,
  input wire cycle_clock_out
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (reset || !master_clear_n);
  a_fetch_step: assert property (
    $changed(prog_addr) |=> $stable(prog_addr)[*3] ##1 $changed(prog_addr))
    else $error("fetch step");
  a_write_once: assert property (
    $rose(file_wr_en) |=> !file_wr_en[*3])
    else $error("write width");
  a_write_last_phase: assert property (
    file_wr_en |=> $changed(prog_addr))
    else $error("write phase");
  a_write_addr_held: assert property (
    file_wr_en |-> $stable(file_addr))
    else $error("write address");
  a_core_regs_kept: assert property (
    file_wr_en |->
      !(file_addr[6:0] inside {7'h00, 7'h02, 7'h03, 7'h04, 7'h0a}))
    else $error("core register write");
  a_clock_shape: assert property (
    rc_mode && $rose(cycle_clock_out) |=>
      cycle_clock_out ##1 !cycle_clock_out[*2] ##1 cycle_clock_out)
    else $error("cycle clock shape");
  a_clock_off: assert property (
    !rc_mode |-> !cycle_clock_out)
    else $error("cycle clock off");
  a_clear_holds: assert property (
    disable iff (reset)
    !master_clear_n[*6] |->
      prog_addr == '0 && !file_wr_en && !cycle_clock_out)
    else $error("clear hold");
  cover property ($rose(file_wr_en));
  cover property (rc_mode && $rose(cycle_clock_out));
  cover property (disable iff (reset) !master_clear_n[*6]);
endmodule
`default_nettype wire

// file: testbench/aac_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module aac_mem_model (
  input wire ref_clk,
  input wire [11:0] prog_addr,
  output logic [13:0] prog_data,
  input wire [7:0] file_addr,
  output logic [7:0] file_rd_data,
  input wire file_wr_en,
  input wire [7:0] file_wr_data
);
  // code and data live apart, each on its own bus
  logic [13:0] prog [0:4095];
  logic [7:0] ram [0:255];
  assign prog_data = prog[prog_addr];
  assign file_rd_data = ram[file_addr];
  always @(posedge ref_clk) begin
    if (file_wr_en) begin
      ram[file_addr] <= file_wr_data;
    end
  end
endmodule
`default_nettype wire

// file: testbench/test_accumulator_alu_core.sv
`timescale 1ns/10ps
`default_nettype none
`include "aac_consts.vh"
module test_accumulator_alu_core;
  localparam logic [1:0] F = `AAC_CLS_FILE;
  localparam logic [1:0] L = `AAC_CLS_LIT;
  localparam logic [1:0] A = `AAC_CLS_ACC;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic master_clear_n = 1'b1;
  logic rc_mode = 1'b0;
  wire [11:0] prog_addr;
  wire [13:0] prog_data;
  wire [7:0] file_addr;
  wire [7:0] file_rd_data;
  wire [7:0] file_wr_data;
  wire [7:0] acc_value;
  wire [7:0] status_value;
  wire file_wr_en;
  wire cycle_clock_out;
  int errors = 0;
  int compares = 0;
  int pc;
  always #50 ref_clk = ~ref_clk;
  aac_core aac_core_inst (.*);
  aac_mem_model aac_mem_model_inst (.*);
  task automatic chk(string s, logic [11:0] e, logic [11:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic put(logic [1:0] c, logic [3:0] op, logic [7:0] lo);
    aac_mem_model_inst.prog[pc] = {c, op, lo};
    pc++;
  endtask
  // unused words store acc to 7f, which marks the end of each program
  task automatic prep;
    @(posedge ref_clk);
    reset <= 1'b1;
    for (int i = 0; i < 4096; i++) aac_mem_model_inst.prog[i] = 14'h00ff;
    pc = 0;
    repeat (20) @(posedge ref_clk);
  endtask
  task automatic go(output int n);
    reset <= 1'b0;
    n = 0;
    while (!(file_wr_en === 1'b1 && file_addr === 8'h7f) && n < 400) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 400) begin
      errors++;
      $display("MISMATCH end marker expected 1 seen 0");
    end
    @(negedge ref_clk);
  endtask
  task automatic run2(logic [7:0] a, logic [1:0] c, logic [3:0] op,
      logic [7:0] b, logic [7:0] ea, logic [2:0] ef);
    int n;
    prep();
    put(L, `AAC_OP_ADD, a);
    put(c, op, b);
    go(n);
    chk("acc", ea, acc_value);
    chk("flags", ef, status_value[2:0]);
  endtask
  task automatic t_arith;
    run2(8'h9c, L, `AAC_OP_SUB, 8'h1c, 8'h80, 3'b010);
    run2(8'h45, L, `AAC_OP_SUB, 8'h45, 8'h00, 3'b111);
    run2(8'hf8, L, `AAC_OP_ADD, 8'h0c, 8'h04, 3'b011);
    run2(8'h81, A, `AAC_OP_RLF, 8'h00, 8'h02, 3'b001);
    run2(8'h03, A, `AAC_OP_RRF, 8'h00, 8'h01, 3'b001);
    run2(8'h0f, L, `AAC_OP_AND, 8'h3c, 8'h0c, 3'b000);
    run2(8'h5a, L, `AAC_OP_XOR, 8'ha5, 8'hff, 3'b000);
    run2(8'h50, L, `AAC_OP_IOR, 8'h0f, 8'h5f, 3'b000);
    run2(8'h01, A, `AAC_OP_DEC, 8'h00, 8'h00, 3'b100);
    run2(8'h37, A, `AAC_OP_SWAP, 8'h00, 8'h73, 3'b000);
    run2(8'h37, A, `AAC_OP_CLR, 8'h00, 8'h00, 3'b100);
    run2(8'h05, F, `AAC_OP_MOVA, 8'h83, 8'h05, 3'b101);
    run2(8'h05, F, `AAC_OP_MOVA, 8'h82, 8'h05, 3'b000);
    $display("test arith done");
  endtask
  task automatic t_file;
    int n;
    prep();
    aac_mem_model_inst.ram[8'h04] = 8'h5a;
    put(L, `AAC_OP_ADD, 8'h30);
    put(F, `AAC_OP_MOVA, 8'h84);
    put(F, `AAC_OP_MOVA, 8'hb0);
    put(F, `AAC_OP_ADD, 8'h00);
    put(F, `AAC_OP_INC, 8'hb0);
    put(A, `AAC_OP_COM, 8'h00);
    go(n);
    chk("acc", 8'h9f, acc_value);
    chk("file 30", 8'h31, aac_mem_model_inst.ram[8'h30]);
    chk("file 04", 8'h5a, aac_mem_model_inst.ram[8'h04]);
    $display("test file done");
  endtask
  task automatic t_branch;
    int n0;
    int n1;
    prep();
    go(n0);
    prep();
    put(L, `AAC_OP_ADD, 8'h01);
    put(`AAC_CLS_GOTO, 4'h0, 8'h05);
    put(L, `AAC_OP_ADD, 8'h10);
    put(L, `AAC_OP_ADD, 8'h10);
    put(L, `AAC_OP_ADD, 8'h10);
    put(L, `AAC_OP_ADD, 8'h02);
    go(n1);
    chk("acc", 8'h03, acc_value);
    chk("clocks", 12'h010, 12'(n1 - n0));
    $display("test branch done");
  endtask
  task automatic t_clock;
    int n;
    int h = 0;
    prep();
    rc_mode <= 1'b1;
    go(n);
    repeat (8) begin
      @(negedge ref_clk);
      if (cycle_clock_out === 1'b1) h++;
    end
    chk("clock highs", 12'h004, 12'(h));
    @(posedge ref_clk);
    master_clear_n <= 1'b0;
    repeat (8) @(negedge ref_clk);
    chk("held fetch", 12'h000, prog_addr);
    @(posedge ref_clk);
    master_clear_n <= 1'b1;
    repeat (16) @(negedge ref_clk);
    chk("resumed", 12'h001, 12'(prog_addr != 12'h000));
    $display("test clock done");
  endtask
  task automatic summarize;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    t_arith();
    t_file();
    t_branch();
    t_clock();
    summarize();
  end
  // tests take about a thousand clocks; ten times that means a hang
  initial begin
    #1000000;
    errors++;
    summarize();
  end
endmodule
bind aac_core aac_core_props #(.PC_W(PC_W)) aac_core_props_inst (.*);
`default_nettype wire
